// ---- ussr_device.sv ----
// Notes on behaviour
// RULE_01 - idle above 3 ms means bus suspend
// RULE_02 - suspend entry sets flag, enabled interrupt
// RULE_03 - live bus status bit: one in suspend
// RULE_04 - firmware aborts suspend if status zero
// RULE_05 - clearing clock-running bit stops internal clocks
// RULE_06 - suspend only after toggle one then zero
// RULE_07 - powered-off: suspend output, clocks off 2 ms
// RULE_08 - resume on 20 ms K, wake pin, select low
// RULE_09 - select wake needs enable bit and VBUS
// RULE_10 - clocks distributed only after oscillator settles
// RULE_11 - wake drops suspend output, sets resume flag
// RULE_12 - normal operation within 15 ms of wake
// RULE_13 - remote wake drives K for 10 ms
// RULE_14 - after wake writes blocked until unlock
// RULE_15 - system waits for suspend output to drop
// RULE_16 - unlock only with data AA37
// RULE_17 - power-off bit selects powered-off suspend behaviour
// RULE_18 - flags sticky until acknowledged; irq follows enables
module ussr_device
    import ussr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    ussr_if.dev bus,
    input wire logic bus_idle,
    input wire logic bus_k_state,
    input wire logic vbus_present,
    input wire logic remote_wake_pin,
    output logic drive_k_state,
    output logic internal_clk_en
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic idle_s, k_s, vbus_s, wake_s, cs_n_s;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sync1_reg <= 5'h1_0;
            sync2_reg <= 5'h1_0;
        end
        else if (clk_en)
        begin
            sync1_reg <= {bus.chip_select_n, remote_wake_pin, vbus_present, bus_k_state, bus_idle};
            sync2_reg <= sync1_reg;
        end
    end
    assign {cs_n_s, wake_s, vbus_s, k_s, idle_s} = sync2_reg;

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    ussr_state_t state_reg, state_next;
    logic [CNT_W-1:0] idle_cnt_reg, idle_cnt_next;
    logic [CNT_W-1:0] k_cnt_reg, k_cnt_next;
    logic [CNT_W-1:0] tmr_reg, tmr_next;
    logic [CNT_W-1:0] rk_cnt_reg, rk_cnt_next;
    logic bus_susp_reg, bus_susp_next;
    logic susp_flag_reg, susp_flag_next;
    logic resm_flag_reg, resm_flag_next;
    logic ie_susp_reg, ie_susp_next;
    logic ie_resm_reg, ie_resm_next;
    logic [2:0] cfg_reg, cfg_next;
    logic remote_reg, remote_next;
    logic lock_reg, lock_next;
    logic susp_out_reg, susp_out_next;
    logic clk_on_reg, clk_on_next;
    logic irq_reg, irq_next;
    logic dk_reg, dk_next;
    logic [5:0] status_reg, status_next;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        sat_inc = (&v) ? v : v + 1'b1;
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    logic wr_ok, wake_host, wake_remote, susp_rise, resume_ev;
    always_comb
    begin
        state_next = state_reg;
        idle_cnt_next = idle_s ? sat_inc(idle_cnt_reg) : '0;
        k_cnt_next = k_s ? sat_inc(k_cnt_reg) : '0;
        tmr_next = tmr_reg;
        rk_cnt_next = rk_cnt_reg;
        bus_susp_next = bus_susp_reg;
        susp_flag_next = susp_flag_reg;
        resm_flag_next = resm_flag_reg;
        ie_susp_next = ie_susp_reg;
        ie_resm_next = ie_resm_reg;
        cfg_next = cfg_reg;
        remote_next = remote_reg;
        lock_next = lock_reg;
        susp_out_next = susp_out_reg;
        clk_on_next = clk_on_reg;
        dk_next = dk_reg;
        wr_ok = bus.cmd_valid && !lock_reg;
        wake_host = (k_cnt_reg >= CNT_W'(KRESUME_CYC)); // [RULE_08]
        wake_remote = wake_s || (!cs_n_s && cfg_reg[CFG_WKCS] && vbus_s); // [RULE_08] [RULE_09]
        susp_rise = 1'b0;
        resume_ev = 1'b0;
        // bus suspend detect and live status
        if (!bus_susp_reg && idle_cnt_reg >= CNT_W'(IDLE_CYC)) // [RULE_01]
        begin
            bus_susp_next = 1'b1;
            susp_rise = 1'b1;
        end
        else if (bus_susp_reg && !idle_s)
            bus_susp_next = 1'b0; // [RULE_03]
        // firmware commands; config, enable and mode writes ignored while locked, ack and unlock accepted
        if (wr_ok && bus.cmd == CMD_CFG)
            cfg_next = bus.cmd_data[2:0];
        if (wr_ok && bus.cmd == CMD_IEN)
        begin
            ie_susp_next = bus.cmd_data[ST_SUSP];
            ie_resm_next = bus.cmd_data[ST_RESM];
        end
        if (bus.cmd_valid && bus.cmd == CMD_ACK)
        begin
            if (bus.cmd_data[ST_SUSP])
                susp_flag_next = 1'b0; // [RULE_18]
            if (bus.cmd_data[ST_RESM])
                resm_flag_next = 1'b0; // [RULE_18]
        end
        if (bus.cmd_valid && bus.cmd == CMD_UNLOCK && bus.cmd_data == UNLOCK_KEY)
            lock_next = 1'b0; // [RULE_14] [RULE_16]
        // clock gating by firmware bit while awake
        if (state_reg == USSR_AWAKE || state_reg == USSR_ARMED || state_reg == USSR_RWAKE)
            clk_on_next = cfg_next[CFG_CLOCK_RUNNING_BIT]; // [RULE_05]
        case (state_reg)
            USSR_AWAKE:
            begin
                if (wr_ok && bus.cmd == CMD_MODE && bus.cmd_data[0])
                    state_next = USSR_ARMED;
            end
            USSR_ARMED:
            begin
                if (wr_ok && bus.cmd == CMD_MODE && !bus.cmd_data[0]) // [RULE_06]
                begin
                    state_next = USSR_SUSP;
                    tmr_next = '0;
                    susp_out_next = cfg_reg[CFG_POWERED_OFF_SELECT]; // [RULE_07] [RULE_17]
                end
            end
            USSR_SUSP:
            begin
                tmr_next = sat_inc(tmr_reg);
                if (cfg_reg[CFG_POWERED_OFF_SELECT] && tmr_reg >= CNT_W'(POWERED_OFF_SELECT_CYC - 1))
                    clk_on_next = 1'b0; // [RULE_07]
                if (wake_host || wake_remote)
                begin
                    state_next = USSR_SETTLE;
                    tmr_next = '0;
                    clk_on_next = 1'b0; // [RULE_10]
                    remote_next = wake_remote && !wake_host; // [RULE_13]
                    rk_cnt_next = '0;
                end
            end
            USSR_SETTLE:
            begin
                tmr_next = sat_inc(tmr_reg);
                if (tmr_reg >= CNT_W'(SETTLE_CYC - 1)) // [RULE_10] [RULE_12]
                begin
                    state_next = remote_reg ? USSR_RWAKE : USSR_AWAKE;
                    dk_next = remote_reg; // [RULE_13]
                    // the run bit was cleared before suspend; without this the clocks would stop again at once
                    cfg_next[CFG_CLOCK_RUNNING_BIT] = 1'b1; // [RULE_10]
                    clk_on_next = 1'b1;
                    susp_out_next = 1'b0; // [RULE_11]
                    resume_ev = 1'b1;
                    lock_next = 1'b1; // [RULE_14]
                end
            end
            USSR_RWAKE:
            begin
                rk_cnt_next = sat_inc(rk_cnt_reg);
                if (rk_cnt_reg >= CNT_W'(RWAKE_K_CYC - 1)) // [RULE_13]
                begin
                    dk_next = 1'b0;
                    remote_next = 1'b0;
                    state_next = USSR_AWAKE;
                end
            end
            default:
                state_next = USSR_AWAKE;
        endcase
        // sticky flags: a new event wins over an acknowledge
        if (susp_rise)
            susp_flag_next = 1'b1; // [RULE_02]
        if (resume_ev)
            resm_flag_next = 1'b1; // [RULE_11]
        irq_next = (susp_flag_next && ie_susp_next) || (resm_flag_next && ie_resm_next); // [RULE_18]
        status_next = {clk_on_next, susp_out_next, lock_next, bus_susp_next, resm_flag_next, susp_flag_next};
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg <= USSR_AWAKE;
            idle_cnt_reg <= '0;
            k_cnt_reg <= '0;
            tmr_reg <= '0;
            rk_cnt_reg <= '0;
            bus_susp_reg <= 1'b0;
            susp_flag_reg <= 1'b0;
            resm_flag_reg <= 1'b0;
            ie_susp_reg <= 1'b0;
            ie_resm_reg <= 1'b0;
            cfg_reg <= CFG_RESET;
            remote_reg <= 1'b0;
            lock_reg <= 1'b0;
            susp_out_reg <= 1'b0;
            clk_on_reg <= 1'b1;
            irq_reg <= 1'b0;
            dk_reg <= 1'b0;
            status_reg <= 6'h20;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            idle_cnt_reg <= idle_cnt_next;
            k_cnt_reg <= k_cnt_next;
            tmr_reg <= tmr_next;
            rk_cnt_reg <= rk_cnt_next;
            bus_susp_reg <= bus_susp_next;
            susp_flag_reg <= susp_flag_next;
            resm_flag_reg <= resm_flag_next;
            ie_susp_reg <= ie_susp_next;
            ie_resm_reg <= ie_resm_next;
            cfg_reg <= cfg_next;
            remote_reg <= remote_next;
            lock_reg <= lock_next;
            susp_out_reg <= susp_out_next;
            clk_on_reg <= clk_on_next;
            irq_reg <= irq_next;
            dk_reg <= dk_next;
            status_reg <= status_next;
        end
    end

    // outputs straight from flip-flops
    assign bus.status = status_reg;
    assign bus.irq = irq_reg;
    assign bus.suspend_out = susp_out_reg;
    assign drive_k_state = dk_reg;
    assign internal_clk_en = clk_on_reg;
endmodule // ussr_device

// ---- ussr_pkg.sv ----
package ussr_pkg;
    // ------------------------------------------------------------
    // timing at the 20 MHz reference clock
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned IDLE_MS = 3;
    localparam int unsigned POWERED_OFF_SELECT_MS = 2;
    localparam int unsigned KRESUME_MS = 20;
    localparam int unsigned WAKE_MAX_MS = 15;
    localparam int unsigned RWAKE_K_MS = 10;
    // idle must last longer than 3 ms: one cycle beyond the figure
    localparam int unsigned IDLE_CYC = CLK_HZ / 1000 * IDLE_MS + 1;
    localparam int unsigned POWERED_OFF_SELECT_CYC = CLK_HZ / 1000 * POWERED_OFF_SELECT_MS;
    localparam int unsigned KRESUME_CYC = CLK_HZ / 1000 * KRESUME_MS;
    localparam int unsigned WAKE_MAX_CYC = CLK_HZ / 1000 * WAKE_MAX_MS;
    localparam int unsigned RWAKE_K_CYC = CLK_HZ / 1000 * RWAKE_K_MS;
    // oscillator and multiplier settling, well inside the wake budget
    localparam int unsigned SETTLE_CYC = 32'h0000_2710;
    localparam int unsigned CNT_W = 24;
    // ------------------------------------------------------------
    // command codes and values
    // ------------------------------------------------------------
    localparam logic [15:0] UNLOCK_KEY = 16'hAA37;
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_CFG = 3'h1;
    localparam logic [2:0] CMD_MODE = 3'h2;
    localparam logic [2:0] CMD_IEN = 3'h3;
    localparam logic [2:0] CMD_ACK = 3'h4;
    localparam logic [2:0] CMD_UNLOCK = 3'h5;
    // config word bits: clock running, wake on select, powered off
    localparam int unsigned CFG_CLOCK_RUNNING_BIT = 0;
    localparam int unsigned CFG_WKCS = 1;
    localparam int unsigned CFG_POWERED_OFF_SELECT = 2;
    localparam logic [2:0] CFG_RESET = 3'h1;
    // status/ack word bits
    localparam int unsigned ST_SUSP = 0;
    localparam int unsigned ST_RESM = 1;
    localparam int unsigned ST_BUS = 2;
    localparam int unsigned ST_LOCK = 3;
    localparam int unsigned ST_SUSPOUT = 4;
    localparam int unsigned ST_CLKON = 5;
    typedef enum logic [4:0] {
        USSR_AWAKE = 5'b00001,
        USSR_ARMED = 5'b00010,
        USSR_SUSP = 5'b00100,
        USSR_SETTLE = 5'b01000,
        USSR_RWAKE = 5'b10000
    } ussr_state_t;
endpackage

// ---- ussr_if.sv ----
// link between the controller end and the firmware end
interface ussr_if;
    logic [2:0] cmd;
    logic [15:0] cmd_data;
    logic cmd_valid;
    logic [5:0] status;
    logic irq;
    logic suspend_out;
    logic chip_select_n;
    modport dev (input cmd, cmd_data, cmd_valid, chip_select_n, output status, irq, suspend_out);
    modport fw (output cmd, cmd_data, cmd_valid, chip_select_n, input status, irq, suspend_out);
endinterface

// ---- ussr_firmware.sv ----
// firmware end: services the suspend interrupt and unlocks after wake
module ussr_firmware
    import ussr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    ussr_if.fw bus,
    input wire logic allow_suspend,
    input wire logic select_n_in,
    output logic system_normal
);
    typedef enum logic [6:0] {
        FW_IDLE = 7'b0000001,
        FW_ACK = 7'b0000010,
        FW_CLK = 7'b0000100,
        FW_SET = 7'b0001000,
        FW_CLR = 7'b0010000,
        FW_UNLK = 7'b0100000,
        FW_IEN = 7'b1000000
    } ussr_fw_t;
    ussr_fw_t st_reg, st_next;
    logic [2:0] cmd_reg, cmd_next;
    logic [15:0] data_reg, data_next;
    logic valid_reg, valid_next;
    logic norm_reg, norm_next;
    logic cs_reg;

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        cmd_next = CMD_NONE;
        data_next = '0;
        valid_next = 1'b0;
        norm_next = !bus.suspend_out && !bus.status[ST_LOCK]; // [RULE_15]
        case (st_reg)
            FW_IDLE:
                if (bus.irq)
                begin
                    st_next = FW_ACK;
                end
            FW_ACK:
            begin
                cmd_next = CMD_ACK;
                data_next = 16'h0003;
                valid_next = 1'b1;
                if (bus.status[ST_LOCK])
                    st_next = FW_UNLK;
                else if (bus.status[ST_BUS] && allow_suspend) // [RULE_04]
                    st_next = FW_CLK;
                else
                    st_next = FW_IDLE;
            end
            FW_CLK:
            begin
                cmd_next = CMD_CFG;
                data_next = 16'h0004; // [RULE_05]
                valid_next = 1'b1;
                st_next = FW_SET;
            end
            FW_SET:
            begin
                cmd_next = CMD_MODE;
                data_next = 16'h0001; // [RULE_06]
                valid_next = 1'b1;
                st_next = FW_CLR;
            end
            FW_CLR:
            begin
                cmd_next = CMD_MODE;
                valid_next = 1'b1; // [RULE_06]
                st_next = FW_IDLE;
            end
            FW_UNLK:
            begin
                cmd_next = CMD_UNLOCK;
                data_next = UNLOCK_KEY; // [RULE_14] [RULE_16]
                valid_next = 1'b1;
                st_next = FW_IDLE;
            end
            // interrupts enabled once after reset, else no event is ever serviced
            FW_IEN:
            begin
                cmd_next = CMD_IEN;
                data_next = 16'h0003; // [RULE_02] [RULE_11]
                valid_next = 1'b1;
                st_next = FW_IDLE;
            end
            default:
                st_next = FW_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_reg <= FW_IEN;
            cmd_reg <= CMD_NONE;
            data_reg <= '0;
            valid_reg <= 1'b0;
            norm_reg <= 1'b0;
            cs_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
            cmd_reg <= cmd_next;
            data_reg <= data_next;
            valid_reg <= valid_next;
            norm_reg <= norm_next;
            cs_reg <= select_n_in;
        end
    end

    assign bus.cmd = cmd_reg;
    assign bus.cmd_data = data_reg;
    assign bus.cmd_valid = valid_reg;
    assign bus.chip_select_n = cs_reg;
    assign system_normal = norm_reg;
endmodule // ussr_firmware

// ---- ussr_assertions.sv ----
// checker for the link between the controller end and the firmware end
module ussr_assertions
    import ussr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] cmd,
    input wire logic [15:0] cmd_data,
    input wire logic cmd_valid,
    input wire logic [5:0] status,
    input wire logic irq,
    input wire logic suspend_out,
    input wire logic chip_select_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // small slack: the exact shutdown edge is the designer's choice
    localparam int LO = POWERED_OFF_SELECT_CYC - 2;
    localparam int HI = POWERED_OFF_SELECT_CYC + 2;
    logic [23:0] on_reg;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // cycles spent in powered-off suspend while clocks still run
    always_ff @(posedge ref_clk)
    begin
        if (rst || !suspend_out || !status[ST_CLKON])
            on_reg <= 24'h00_0000;
        else
            on_reg <= on_reg + 24'h00_0001;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_UNLOCK_BAD: assert property (
        cmd_valid && cmd == CMD_UNLOCK && cmd_data != UNLOCK_KEY && status[ST_LOCK] |=> status[ST_LOCK])
        else $error("wrong key released the lock");
    AST_UNLOCK_GOOD: assert property (
        cmd_valid && cmd == CMD_UNLOCK && cmd_data == UNLOCK_KEY |=> !status[ST_LOCK])
        else $error("key did not release the lock");
    AST_LOCKED_CFG: assert property (
        status[ST_LOCK] && cmd_valid && cmd == CMD_CFG |=> $stable(status[ST_CLKON]))
        else $error("locked config write took effect");
    AST_CLOCK_RUNNING_BIT_OFF: assert property (
        !status[ST_LOCK] && !suspend_out && cmd_valid && cmd == CMD_CFG && !cmd_data[CFG_CLOCK_RUNNING_BIT]
        |=> !status[ST_CLKON])
        else $error("clocks kept running");
    AST_FLAG_STICKY: assert property (
        status[ST_SUSP] && !(cmd_valid && cmd == CMD_ACK && cmd_data[ST_SUSP]) |=> status[ST_SUSP])
        else $error("suspend flag lost without ack");
    AST_IRQ_CAUSE: assert property (
        irq |-> status[ST_SUSP] || status[ST_RESM])
        else $error("irq without a flag");
    AST_GO_TOGGLE: assert property (
        $rose(suspend_out) |-> $past(cmd_valid && cmd == CMD_MODE && !cmd_data[0]))
        else $error("suspend entered without toggle");
    AST_RESUME_OUT: assert property (
        $rose(status[ST_RESM]) |-> !suspend_out && status[ST_LOCK] && status[ST_CLKON])
        else $error("wake state wrong");
    AST_POWERED_OFF_SELECT_LATE: assert property (
        on_reg <= HI)
        else $error("clocks not stopped in time");
    AST_POWERED_OFF_SELECT_EARLY: assert property (
        suspend_out && $fell(status[ST_CLKON]) |-> on_reg >= LO)
        else $error("clocks stopped early");
    COV_SUSP: cover property ($rose(status[ST_SUSP]));
    COV_WAKE: cover property ($rose(status[ST_RESM]));
    COV_UNLOCK: cover property ($fell(status[ST_LOCK]));
endmodule // ussr_assertions

// ---- ussr_test.sv ----
// pair a: both design ends; pair b: one device driven by the bench
module ussr_test;
    import ussr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rst, idle_a, wake_a, sel_a, allow_a, k_a, idle_b, k_b, vbus_b, wake_b;
    logic dk_a, ice_a, norm_a, dk_b, ice_b;
    logic m_clk, m_sout, m_lock, m_bus, m_go;
    logic [1:0] m_fl, m_ien;
    logic [2:0] m_cfg;
    int num_errors, n_compared, cyc, seed;
    ussr_if if_a();
    ussr_if if_b();
    ussr_device i_ussr_device (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .bus(if_a), .bus_idle(idle_a),
        .bus_k_state(k_a), .vbus_present(1'b1), .remote_wake_pin(wake_a), .drive_k_state(dk_a),
        .internal_clk_en(ice_a));
    ussr_firmware i_ussr_firmware (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .bus(if_a),
        .allow_suspend(allow_a), .select_n_in(sel_a), .system_normal(norm_a));
    ussr_device i_ussr_device_b (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .bus(if_b), .bus_idle(idle_b),
        .bus_k_state(k_b), .vbus_present(vbus_b), .remote_wake_pin(wake_b), .drive_k_state(dk_b),
        .internal_clk_en(ice_b));
    ussr_assertions i_ussr_assertions (.ref_clk(ref_clk), .rst(rst), .cmd(if_a.cmd), .cmd_data(if_a.cmd_data),
        .cmd_valid(if_a.cmd_valid), .status(if_a.status), .irq(if_a.irq), .suspend_out(if_a.suspend_out),
        .chip_select_n(if_a.chip_select_n));

    // ------------------------------------------------------------
    // compare and helper tasks
    // ------------------------------------------------------------
    task automatic chk_b(input string name, input logic e, input logic g);
        n_compared++;
        if (g !== e)
        begin
            $display("FAIL %s expected %b seen %b", name, e, g);
            num_errors++;
        end
    endtask

    task automatic chk_v(input string name, input logic [5:0] e, input logic [5:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("FAIL %s expected %h seen %h", name, e, g);
            num_errors++;
        end
    endtask

    // model status and irq of pair b against the device
    task automatic model_chk(input string name);
        chk_v(name, {m_clk, m_sout, m_lock, m_bus, m_fl}, if_b.status);
        chk_b(name, |(m_fl & m_ien), if_b.irq);
    endtask

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask

    // one-cycle command pulse; the model follows the same command
    task automatic send(input logic [2:0] c, input logic [15:0] d);
        @(posedge ref_clk);
        if_b.cmd <= c;
        if_b.cmd_data <= d;
        if_b.cmd_valid <= 1'b1;
        @(posedge ref_clk);
        if_b.cmd_valid <= 1'b0;
        if (c == CMD_ACK)
            m_fl = m_fl & ~d[1:0];
        if (c == CMD_UNLOCK && d == UNLOCK_KEY)
            m_lock = 1'b0;
        if (!m_lock && c == CMD_CFG)
        begin
            m_cfg = d[2:0];
            m_clk = d[0];
        end
        if (!m_lock && c == CMD_IEN)
            m_ien = d[1:0];
        if (!m_lock && c == CMD_MODE)
        begin
            if (m_go && !d[0])
                m_sout = m_cfg[CFG_POWERED_OFF_SELECT];
            m_go = d[0];
        end
        #1;
        model_chk("status");
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic run_a();
        int n;
        @(posedge ref_clk);
        idle_a <= 1'b1;
        allow_a <= 1'b1;
        for (n = 0; n < IDLE_CYC + 9 && if_a.status[ST_SUSP] !== 1'b1; n++) step();
        chk_b("fw idle", 1'b1, n > IDLE_CYC - 4);
        chk_b("fw flag", 1'b1, if_a.status[ST_SUSP]);
        for (n = 0; n < POWERED_OFF_SELECT_CYC + 999 && ice_a !== 1'b0; n++) step();
        chk_b("fw clk off", 1'b0, ice_a);
        @(posedge ref_clk);
        idle_a <= 1'b0;
        wake_a <= 1'b1;
        for (n = 0; n < WAKE_MAX_CYC && dk_a !== 1'b1; n++) step();
        chk_b("fw remote k", 1'b1, dk_a);
        @(posedge ref_clk);
        wake_a <= 1'b0;
        for (n = 0; n < WAKE_MAX_CYC && norm_a !== 1'b1; n++) step();
        chk_b("fw normal", 1'b1, norm_a);
        chk_b("fw lock", 1'b0, if_a.status[ST_LOCK]);
        $display("test a done");
    endtask

    task automatic run_b();
        logic [31:0] r;
        int n;
        send(CMD_IEN, 16'h0003);
        send(CMD_CFG, 16'h0007);
        // idle detection and powered-off shutdown run side by side to keep the run short
        @(posedge ref_clk);
        idle_b <= 1'b1;
        send(CMD_MODE, 16'h0001);
        send(CMD_MODE, 16'h0000);
        repeat (POWERED_OFF_SELECT_CYC - 4) @(posedge ref_clk);
        #1;
        model_chk("clk held");
        repeat (8) @(posedge ref_clk);
        m_clk = 1'b0;
        #1;
        model_chk("clk off");
        repeat (IDLE_CYC - POWERED_OFF_SELECT_CYC - 12) @(posedge ref_clk);
        #1;
        model_chk("early idle");
        for (n = 0; n < 20 && if_b.status[ST_SUSP] !== 1'b1; n++) step();
        m_fl[0] = 1'b1;
        m_bus = 1'b1;
        model_chk("idle");
        send(CMD_ACK, 16'h0001);
        @(posedge ref_clk);
        vbus_b <= 1'b0;
        idle_b <= 1'b0;
        if_b.chip_select_n <= 1'b0;
        repeat (200) step();
        m_bus = 1'b0;
        model_chk("no vbus");
        @(posedge ref_clk);
        vbus_b <= 1'b1;
        for (n = 0; n < WAKE_MAX_CYC && if_b.status[ST_RESM] !== 1'b1; n++) step();
        chk_b("settle", 1'b1, n > SETTLE_CYC - 8);
        chk_b("wake time", 1'b1, n < WAKE_MAX_CYC);
        {m_clk, m_sout, m_lock, m_fl[1]} = 4'hB;
        model_chk("wake");
        chk_b("remote k", 1'b1, dk_b);
        @(posedge ref_clk);
        if_b.chip_select_n <= 1'b1;
        repeat (1000) step();
        chk_b("k held", 1'b1, dk_b);
        send(CMD_CFG, 16'h0000);
        // random wrong keys; a draw equal to the key is bent away
        repeat (3)
        begin
            r = $random(seed);
            send(CMD_UNLOCK, (r[15:0] == UNLOCK_KEY) ? 16'h0000 : r[15:0]);
        end
        send(CMD_UNLOCK, UNLOCK_KEY);
        send(CMD_ACK, 16'h0002);
        send(CMD_CFG, 16'h0000);
        $display("test b done");
    endtask

    // clock and cycle ceiling
    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            num_errors++;
            end_sim();
        end
    end

    // main sequence: both pairs run side by side to save cycles
    initial
    begin
        {ref_clk, idle_a, wake_a, allow_a, k_a, idle_b, k_b, wake_b} = 8'h00;
        {rst, sel_a, vbus_b} = 3'h7;
        if_b.cmd = CMD_NONE;
        if_b.cmd_data = 16'h0000;
        if_b.cmd_valid = 1'b0;
        if_b.chip_select_n = 1'b1;
        {m_clk, m_sout, m_lock, m_bus, m_go, m_fl, m_ien, m_cfg} = 12'h801;
        num_errors = 0;
        n_compared = 0;
        cyc = 0;
        seed = 32'h035a_38e4;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        step();
        model_chk("reset");
        fork
            run_a();
            run_b();
        join
        end_sim();
    end
endmodule // ussr_test
